// ---- common/sfsr_pkg.sv ----
// Opcodes, reset values and layout constants for the status-register command block
package sfsr_pkg;

  // Status register file
  localparam int        STATUS_COUNT    = 6;
  localparam int        STATUS_WIDTH    = 8;
  localparam logic [7:0] STATUS_RESET   = 8'h00;
  localparam int        PD_SELECT_BIT   = 7;   // Depth select bit inside register four

  // Register numbers as sent in the address byte
  localparam logic [7:0] ADDR_FIRST      = 8'h01;
  localparam logic [7:0] ADDR_INDIRECT_LO = 8'h04;
  localparam logic [7:0] ADDR_LAST       = 8'h06;

  // Opcodes
  localparam logic [7:0] OP_READ_ONE   = 8'h05;
  localparam logic [7:0] OP_READ_TWO   = 8'h35;
  localparam logic [7:0] OP_READ_THREE = 8'h15;
  localparam logic [7:0] OP_READ_ADDR  = 8'h65;
  localparam logic [7:0] OP_WRITE_ONE  = 8'h01;
  localparam logic [7:0] OP_WRITE_TWO  = 8'h31;
  localparam logic [7:0] OP_WRITE_THREE = 8'h11;
  localparam logic [7:0] OP_WRITE_ADDR = 8'h71;
  localparam logic [7:0] OP_RESET_ARM  = 8'h66;
  localparam logic [7:0] OP_RESET_GO   = 8'h99;
  localparam logic [7:0] OP_POWER_DOWN = 8'hB9;
  localparam logic [7:0] OP_RESUME     = 8'hAB;

  // Byte positions inside a frame
  localparam logic [3:0] BYTE_OPCODE = 4'h0;
  localparam logic [3:0] BYTE_SECOND = 4'h1;
  localparam logic [3:0] BYTE_THIRD  = 4'h2;
  localparam logic [3:0] BYTE_LIMIT  = 4'hF;
  localparam logic [2:0] BIT_LAST    = 3'h7;

  // Power state of the core
  typedef enum logic [1:0] {PWR_ACTIVE, PWR_DEEP, PWR_ULTRA} power_type;

endpackage

// ---- logic/sfsr_top.sv ----
// Serial status-register command interpreter with link-clock front end
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Formats name lanes per phase; here every phase uses one lane, data out on serial out.
// - Opcode 05h returns status register one as one byte, no address or dummy.
// - Opcode 35h returns status register two as one byte, no address or dummy.
// - Opcode 15h returns status register three as one byte, no address or dummy.
// - Opcode 65h, address byte, dummy byte, then one byte per register.
// - Opcode 01h then one data byte stores status register one.
// - Opcode 31h then one data byte stores status register two.
// - Opcode 11h then one data byte stores status register three.
// - Opcode 71h, address byte, data byte loads addressed register four to six.
// - Read at address 01h with select held low steps through all six registers.
// - A second data byte after 01h goes into status register two.
// - B9h enters deep power-down if depth bit set, ultra deep otherwise.
module sfsr_top
  import sfsr_pkg::*;
(
  // System clock and reset
  input  wire logic CLK_IN,
  input  wire logic RST_IN,
  // Serial link from the host
  input  wire logic SCK_IN,
  input  wire logic CS_N_IN,
  input  wire logic SI_IN,
  output var  logic SO_OUT,
  output var  logic SO_OE_OUT,
  // Power state towards the core
  output var  logic DEEP_PD_OUT,
  output var  logic ULTRA_PD_OUT
);
  import sfsr_pkg::*;

  // Link-domain frame state
  logic [2:0]        bit_cnt;
  logic [3:0]        byte_cnt;
  logic [6:0]        shift_in;
  logic [7:0]        opcode;
  logic [7:0]        read_ptr;
  logic              auto_step;
  logic [7:0]        tx_byte;
  logic              tx_active;
  logic [7:0]        status_reg [STATUS_COUNT];
  logic              reset_armed;
  logic              frame_rst;
  logic              byte_done;
  logic [7:0]        rx_byte;
  logic              pd_tgl;
  logic              wake_tgl;
  logic              pd_deep;

  // System-domain crossing state
  logic [1:0]        cs_sync;
  logic [1:0]        pd_sync;
  logic [1:0]        wake_sync;
  logic [1:0]        deep_sync;
  logic              pd_seen;
  logic              wake_seen;
  logic              pd_pending;
  logic              pd_pending_deep;
  logic              wake_pending;
  power_type         power_state;

  // Register read by number; out-of-range numbers read as zero
  function automatic logic [7:0] reg_by_num(input logic [7:0] num);
    logic [7:0] val;
    val = STATUS_RESET;
    for (int i = 0; i < STATUS_COUNT; i++) begin
      if (num == 8'(i + 1)) begin
        val = status_reg[i];
      end
    end
    return val;
  endfunction

  // A deselected link parks all frame state; select acts as the frame reset
  assign frame_rst = RST_IN | CS_N_IN;
  // Byte assembled MSB first from the seven earlier bits and this one
  assign rx_byte   = {shift_in, SI_IN};
  assign byte_done = (bit_cnt == BIT_LAST);

  // Bit and byte counters, restarted by every new frame
  always_ff @(posedge SCK_IN or posedge frame_rst) begin
    if (frame_rst) begin
      bit_cnt  <= 3'h0;
      byte_cnt <= BYTE_OPCODE;
    end else begin
      bit_cnt <= bit_cnt + 3'h1;
      if (byte_done && byte_cnt != BYTE_LIMIT) begin
        byte_cnt <= byte_cnt + 4'h1; // Saturates; long streams never wrap
      end
    end
  end

  // Input shifter on the single data-in lane
  always_ff @(posedge SCK_IN or posedge frame_rst) begin
    if (frame_rst) begin
      shift_in <= 7'h00;
    end else begin
      shift_in <= rx_byte[6:0];
    end
  end

  // Opcode and address capture
  always_ff @(posedge SCK_IN or posedge frame_rst) begin
    if (frame_rst) begin
      opcode    <= 8'h00;
      read_ptr  <= 8'h00;
      auto_step <= 1'b0;
    end else if (byte_done) begin
      if (byte_cnt == BYTE_OPCODE) begin
        opcode <= rx_byte;
      end else if (byte_cnt == BYTE_SECOND && (opcode == OP_READ_ADDR || opcode == OP_WRITE_ADDR)) begin
        read_ptr  <= rx_byte;
        auto_step <= (opcode == OP_READ_ADDR) && (rx_byte == ADDR_FIRST);
      end else if (byte_cnt >= BYTE_THIRD && opcode == OP_READ_ADDR && auto_step && read_ptr <= ADDR_LAST) begin
        // Stops one past the last register, so a long stream cannot wrap back into range
        read_ptr <= read_ptr + 8'h01;
      end
    end
  end

  // Output byte selection; loaded on the rising edge that ends the byte before
  always_ff @(posedge SCK_IN or posedge frame_rst) begin
    if (frame_rst) begin
      tx_byte   <= 8'h00;
      tx_active <= 1'b0;
    end else if (byte_done) begin
      if (byte_cnt == BYTE_OPCODE) begin
        // Fixed reads start right after the opcode, no address or dummy
        unique case (rx_byte)
          OP_READ_ONE: begin
            tx_byte   <= status_reg[0];
            tx_active <= 1'b1;
          end
          OP_READ_TWO: begin
            tx_byte   <= status_reg[1];
            tx_active <= 1'b1;
          end
          OP_READ_THREE: begin
            tx_byte   <= status_reg[2];
            tx_active <= 1'b1;
          end
          default: begin
            tx_active <= 1'b0;
          end
        endcase
      end else if (opcode == OP_READ_ADDR) begin
        if (byte_cnt == BYTE_SECOND) begin
          tx_active <= 1'b0; // Dummy byte follows the address
        end else if (byte_cnt == BYTE_THIRD) begin
          tx_byte   <= reg_by_num(read_ptr);
          tx_active <= 1'b1;
        end else if (auto_step && read_ptr <= ADDR_LAST) begin
          // Pointer already advanced at the end of the byte before
          tx_byte   <= reg_by_num(read_ptr);
          tx_active <= 1'b1;
        end else begin
          tx_active <= 1'b0; // One byte, or all six already sent
        end
      end else if (opcode == OP_READ_ONE) begin
        tx_active <= 1'b0;
      end else if (opcode == OP_READ_TWO) begin
        tx_active <= 1'b0;
      end else if (opcode == OP_READ_THREE) begin
        tx_active <= 1'b0;
      end
    end
  end

  // Output lane driven on the falling edge so data is settled at the next rise
  always_ff @(negedge SCK_IN or posedge frame_rst) begin
    if (frame_rst) begin
      SO_OUT    <= 1'b0;
      SO_OE_OUT <= 1'b0;
    end else begin
      SO_OUT    <= tx_byte[BIT_LAST - bit_cnt];
      SO_OE_OUT <= tx_active;
    end
  end

  // Status registers; only the system reset or a software reset clears them.
  // Writes land on the last data bit, so a frame cut short writes nothing.
  always_ff @(posedge SCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      for (int i = 0; i < STATUS_COUNT; i++) begin
        status_reg[i] <= STATUS_RESET;
      end
    end else if (!CS_N_IN && byte_done) begin
      if (byte_cnt == BYTE_OPCODE && rx_byte == OP_RESET_GO && reset_armed) begin
        for (int i = 0; i < STATUS_COUNT; i++) begin
          status_reg[i] <= STATUS_RESET;
        end
      end else if (byte_cnt == BYTE_SECOND) begin
        if (opcode == OP_WRITE_ONE) begin
          status_reg[0] <= rx_byte;
        end else if (opcode == OP_WRITE_TWO) begin
          status_reg[1] <= rx_byte;
        end else if (opcode == OP_WRITE_THREE) begin
          status_reg[2] <= rx_byte;
        end
      end else if (byte_cnt == BYTE_THIRD) begin
        if (opcode == OP_WRITE_ONE) begin
          status_reg[1] <= rx_byte;
        end else if (opcode == OP_WRITE_ADDR) begin
          for (int i = 3; i < STATUS_COUNT; i++) begin
            if (read_ptr == 8'(i + 1)) begin
              status_reg[i] <= rx_byte;
            end
          end
        end
      end
    end
  end

  // Reset arming survives the frame gap but any other opcode disarms it
  always_ff @(posedge SCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      reset_armed <= 1'b0;
    end else if (!CS_N_IN && byte_done && byte_cnt == BYTE_OPCODE) begin
      reset_armed <= (rx_byte == OP_RESET_ARM);
    end
  end

  // Power events leave the link domain as toggles; depth is held beside them
  always_ff @(posedge SCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      pd_tgl   <= 1'b0;
      wake_tgl <= 1'b0;
      pd_deep  <= 1'b0;
    end else if (!CS_N_IN && byte_done && byte_cnt == BYTE_OPCODE) begin
      if (rx_byte == OP_POWER_DOWN) begin
        pd_tgl  <= ~pd_tgl;
        pd_deep <= status_reg[3][PD_SELECT_BIT];
      end else if (rx_byte == OP_RESUME) begin
        wake_tgl <= ~wake_tgl;
      end
    end
  end

  // Two-flop synchronisers into the system clock
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      cs_sync   <= 2'b11;
      pd_sync   <= 2'b00;
      wake_sync <= 2'b00;
      deep_sync <= 2'b00;
    end else begin
      cs_sync   <= {cs_sync[0], CS_N_IN};
      pd_sync   <= {pd_sync[0], pd_tgl};
      wake_sync <= {wake_sync[0], wake_tgl};
      deep_sync <= {deep_sync[0], pd_deep};
    end
  end

  // Edge memory for the toggles, read only from the second stage
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      pd_seen   <= 1'b0;
      wake_seen <= 1'b0;
    end else begin
      pd_seen   <= pd_sync[1];
      wake_seen <= wake_sync[1];
    end
  end

  // Commands wait for the frame to close, since a power-down must not cut it
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      pd_pending      <= 1'b0;
      pd_pending_deep <= 1'b0;
      wake_pending    <= 1'b0;
    end else begin
      if (pd_sync[1] != pd_seen) begin
        pd_pending <= 1'b1;
      end else if (cs_sync[1]) begin
        pd_pending <= 1'b0;
      end
      // Depth may reach the sync a cycle apart from the toggle; it is long settled when the frame closes
      pd_pending_deep <= deep_sync[1];
      if (wake_sync[1] != wake_seen) begin
        wake_pending <= 1'b1;
      end else if (cs_sync[1]) begin
        wake_pending <= 1'b0;
      end
    end
  end

  // Power state machine in the system domain
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      power_state <= PWR_ACTIVE;
    end else if (cs_sync[1]) begin
      unique case (power_state)
        PWR_ACTIVE: begin
          if (pd_pending) begin
            power_state <= pd_pending_deep ? PWR_DEEP : PWR_ULTRA;
          end
        end
        PWR_DEEP, PWR_ULTRA: begin
          if (wake_pending) begin
            power_state <= PWR_ACTIVE;
          end
        end
        default: begin
          power_state <= PWR_ACTIVE;
        end
      endcase
    end
  end

  // Registered power outputs
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      DEEP_PD_OUT  <= 1'b0;
      ULTRA_PD_OUT <= 1'b0;
    end else begin
      DEEP_PD_OUT  <= (power_state == PWR_DEEP);
      ULTRA_PD_OUT <= (power_state == PWR_ULTRA);
    end
  end

endmodule
`default_nettype wire

// ---- test/sfsr_chk.sv ----
// Checker for link framing, output enable and power outputs of the status block
`timescale 1ns/1ps
`default_nettype none
module sfsr_chk
  import sfsr_pkg::*;
(
  // Ports of the block under check
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic SCK_IN,
  input wire logic CS_N_IN,
  input wire logic SI_IN,
  input wire logic SO_OUT,
  input wire logic SO_OE_OUT,
  input wire logic DEEP_PD_OUT,
  input wire logic ULTRA_PD_OUT
);
  logic [6:0] cnt;
  logic [7:0] sh;
  logic [7:0] op;
  logic [7:0] adr;
  logic       short_rd;
  logic       quiet;
  // Rise count and captured bytes; select high clears the count, bytes are only read past it
  always_ff @(posedge SCK_IN or posedge CS_N_IN) begin
    if (CS_N_IN) begin
      cnt <= 7'h00;
    end else begin
      cnt <= (cnt == 7'h7F) ? cnt : cnt + 7'h01;
      sh <= {sh[6:0], SI_IN};
      if (cnt == 7'h07) op <= {sh[6:0], SI_IN};
      if (cnt == 7'h0F) adr <= {sh[6:0], SI_IN};
    end
  end
  // Opcode classes
  assign short_rd = op inside {OP_READ_ONE, OP_READ_TWO, OP_READ_THREE};
  assign quiet = !(short_rd || op == OP_READ_ADDR);

  rd_short_a: assert property (@(posedge SCK_IN) disable iff (RST_IN || CS_N_IN)
    short_rd && cnt inside {[8:15]} |-> SO_OE_OUT) else $error("short read not driven");
  rd_end_a: assert property (@(posedge SCK_IN) disable iff (RST_IN || CS_N_IN)
    short_rd && cnt >= 16 |-> !SO_OE_OUT) else $error("short read overran");
  addr_rd_a: assert property (@(posedge SCK_IN) disable iff (RST_IN || CS_N_IN)
    op == OP_READ_ADDR && adr inside {[2:6]} && cnt inside {[24:31]} |-> SO_OE_OUT)
    else $error("indexed read not driven");
  one_byte_a: assert property (@(posedge SCK_IN) disable iff (RST_IN || CS_N_IN)
    op == OP_READ_ADDR && adr inside {[2:6]} && cnt >= 32 |-> !SO_OE_OUT) else $error("indexed read overran");
  stream_on_a: assert property (@(posedge SCK_IN) disable iff (RST_IN || CS_N_IN)
    op == OP_READ_ADDR && adr == ADDR_FIRST && cnt inside {[24:71]} |-> SO_OE_OUT) else $error("stream cut short");
  stream_end_a: assert property (@(posedge SCK_IN) disable iff (RST_IN || CS_N_IN)
    op == OP_READ_ADDR && adr == ADDR_FIRST && cnt >= 72 |-> !SO_OE_OUT) else $error("stream overran");
  quiet_op_a: assert property (@(posedge SCK_IN) disable iff (RST_IN || CS_N_IN)
    quiet && cnt >= 8 |-> !SO_OE_OUT) else $error("output driven on non-read");
  idle_hiz_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    CS_N_IN |-> !SO_OE_OUT) else $error("output driven while deselected");
  pd_excl_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    !(DEEP_PD_OUT && ULTRA_PD_OUT)) else $error("both power states");
  pd_frame_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    !$stable(DEEP_PD_OUT) || !$stable(ULTRA_PD_OUT) |-> CS_N_IN && $past(CS_N_IN))
    else $error("power changed inside frame");
endmodule
bind sfsr_top sfsr_chk chk (.CLK_IN, .RST_IN, .SCK_IN, .CS_N_IN, .SI_IN, .SO_OUT, .SO_OE_OUT,
  .DEEP_PD_OUT, .ULTRA_PD_OUT);
`default_nettype wire

// ---- test/sfsr_host.sv ----
// Host controller model driving the serial link in mode 0
`timescale 1ns/1ps
`default_nettype none
module sfsr_host (
  // Link towards the device
  output var  logic sck,
  output var  logic cs_n,
  output var  logic si,
  input  wire logic so,
  input  wire logic so_oe
);
  logic [79:0] rx;
  logic [79:0] oe;
  // Link parked: clock low, select high
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  // One frame of n bytes on one lane each way, first bit leftmost
  task automatic xfer(input int n, input logic [79:0] tx);
    rx = '0;
    oe = '0;
    #31 cs_n = 1'b0;
    for (int i = 0; i < 8 * n; i++) begin
      si = tx[79-i];
      #62.5 sck = 1'b1;
      rx[79-i] = so;
      oe[79-i] = so_oe;
      #62.5 sck = 1'b0;
    end
    #62.5 cs_n = 1'b1;
    si = ~si;  // Released line must not keep showing the last bit
    #300;      // Gap lets the system clock see the frame end
  endtask
endmodule
`default_nettype wire

// ---- test/sfsr_top_bench.sv ----
// Self-checking bench for the status-register command block
`timescale 1ns/1ps
`default_nettype none
module sfsr_top_bench;
  import sfsr_pkg::*;
  logic clk, rst, sck, cs_n, si, so, so_oe, deep, ultra;
  int error_cnt = 0;
  int compares = 0;
  logic [7:0] val [6] = '{8'hA5, 8'h3C, 8'hC3, 8'h5A, 8'h96, 8'h69};
  logic [7:0] wo [3] = '{OP_WRITE_ONE, OP_WRITE_TWO, OP_WRITE_THREE};
  logic [7:0] ro [3] = '{OP_READ_ONE, OP_READ_TWO, OP_READ_THREE};

  sfsr_top dut (.CLK_IN(clk), .RST_IN(rst), .SCK_IN(sck), .CS_N_IN(cs_n), .SI_IN(si),
    .SO_OUT(so), .SO_OE_OUT(so_oe), .DEEP_PD_OUT(deep), .ULTRA_PD_OUT(ultra));
  sfsr_host host (.sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe));

  // System clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Read one byte after n header bytes; enable must be off in the opcode and on in the data
  task automatic rd(input int n, input logic [79:0] tx, input logic [7:0] exp);
    host.xfer(n + 1, tx);
    chk("opcode enable", 8'h00, host.oe[79 -: 8]);
    chk("read enable", 8'hFF, host.oe[79-8*n -: 8]);
    chk("read data", exp, host.rx[79-8*n -: 8]);
  endtask

  task automatic t_direct();
    for (int i = 0; i < 3; i++) begin
      rd(1, {ro[i], 72'h0}, STATUS_RESET);
      host.xfer(2, {wo[i], val[i], 64'h0});
      rd(1, {ro[i], 72'h0}, val[i]);
    end
  endtask

  task automatic t_indirect();
    for (int i = 0; i < 3; i++) begin
      host.xfer(3, {OP_WRITE_ADDR, ADDR_INDIRECT_LO + 8'(i), val[i+3], 56'h0});
      rd(3, {OP_READ_ADDR, ADDR_INDIRECT_LO + 8'(i), 8'h00, 56'h0}, val[i+3]);
    end
  endtask

  task automatic t_stream();
    host.xfer(10, {OP_READ_ADDR, ADDR_FIRST, 64'h0});
    for (int i = 0; i < 6; i++) chk("stream byte", val[i], host.rx[55-8*i -: 8]);
    chk("stream stop", 8'h00, host.oe[7:0]);
  endtask

  task automatic t_legacy();
    host.xfer(3, {OP_WRITE_ONE, 8'h11, 8'h22, 56'h0});
    rd(1, {OP_READ_ONE, 72'h0}, 8'h11);
    rd(1, {OP_READ_TWO, 72'h0}, 8'h22);
  endtask

  task automatic t_refuse();
    host.xfer(3, {OP_WRITE_ADDR, 8'h07, 8'hFF, 56'h0});
    rd(3, {OP_READ_ADDR, ADDR_LAST, 8'h00, 56'h0}, val[5]);
    host.xfer(3, {8'h9F, 72'h0});
    chk("unknown enable", 8'h00, host.oe[71 -: 8] | host.oe[63 -: 8]);
    host.xfer(3, {OP_READ_ONE, 72'h0});
    chk("after read", 8'h00, host.oe[63 -: 8]);
  endtask

  task automatic t_power();
    for (int i = 0; i < 2; i++) begin
      host.xfer(3, {OP_WRITE_ADDR, ADDR_INDIRECT_LO, i ? 8'h00 : 8'h80, 56'h0});
      host.xfer(1, {OP_POWER_DOWN, 72'h0});
      chk("deep", {7'h00, !i[0]}, {7'h00, deep});
      chk("ultra", {7'h00, i[0]}, {7'h00, ultra});
      host.xfer(1, {OP_RESUME, 72'h0});
      chk("resume", 8'h00, {6'h00, deep, ultra});
    end
  endtask

  task automatic t_soft_reset();
    host.xfer(1, {OP_RESET_ARM, 72'h0});
    host.xfer(2, {OP_READ_ONE, 72'h0});
    host.xfer(1, {OP_RESET_GO, 72'h0});
    rd(1, {OP_READ_ONE, 72'h0}, 8'h11);
    host.xfer(1, {OP_RESET_ARM, 72'h0});
    host.xfer(1, {OP_RESET_GO, 72'h0});
    rd(1, {OP_READ_ONE, 72'h0}, STATUS_RESET);
  endtask

  task automatic summarize();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Hang guard, well beyond the roughly 100 us the sequence needs
  initial begin
    #2000000;
    error_cnt++;
    summarize();
  end

  // Reset, then the scenarios in order
  initial begin
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    t_direct();
    t_indirect();
    t_stream();
    t_legacy();
    t_refuse();
    t_power();
    t_soft_reset();
    summarize();
  end
endmodule
`default_nettype wire
